// >>> test/smcg_core_asserts.sv
// Purpose: Checker for sleep gating outputs
// Assumes: Sees only top-level ports
// Notes:   Bind at foot of file
`timescale 1ns/100ps
module smcg_core_asserts (
    // Clock and reset
    input wire logic                ref_clk_i,
    input wire logic                rst_n_i,
    // Watched outputs
    input wire smcg_pkg::smcg_clk_t clk_en_o,
    input wire smcg_pkg::smcg_sub_t sub_en_o,
    input wire logic                tdo_oe_o,
    input wire logic                sleeping_o,
    input wire logic                wake_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_core; sleeping_o |-> !clk_en_o.core_clock; endproperty
    a_core: assert property (p_core) else $error("core clock on in sleep");
    property p_wkrun; wake_o |-> clk_en_o.core_clock && !sleeping_o; endproperty
    a_wkrun: assert property (p_wkrun) else $error("wake without clocks");
    property p_fell; $fell(sleeping_o) |-> wake_o; endproperty
    a_fell: assert property (p_fell) else $error("sleep end without wake");
    property p_pulse; wake_o |=> !wake_o; endproperty
    a_pulse: assert property (p_pulse) else $error("wake pulse too long");
    property p_asy; clk_en_o.async_timer_clock == clk_en_o.timer_osc; endproperty
    a_asy: assert property (p_asy) else $error("async clock and osc differ");
    property p_cmp;
        sleeping_o && !clk_en_o.converter_clock |-> !sub_en_o.comparator; endproperty
    a_cmp: assert property (p_cmp) else $error("comparator on in deep sleep");
    property p_ref; sub_en_o.converter || sub_en_o.brownout |-> sub_en_o.vref; endproperty
    a_ref: assert property (p_ref) else $error("reference off while needed");
    property p_ibuf; $past(rst_n_i) |->
        sub_en_o.input_buffer == (clk_en_o.io_clock || clk_en_o.converter_clock); endproperty
    a_ibuf: assert property (p_ibuf) else $error("input buffer mismatch");
    property p_oe; !sub_en_o.jtag && !$past(sub_en_o.jtag) |-> !tdo_oe_o; endproperty
    a_oe: assert property (p_oe) else $error("tdo driven with port off");
endmodule

bind smcg_core smcg_core_asserts i_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .clk_en_o(clk_en_o), .sub_en_o(sub_en_o), .tdo_oe_o(tdo_oe_o),
    .sleeping_o(sleeping_o), .wake_o(wake_o));

// >>> test/smcg_partner.sv
// Purpose: Core and peripheral side model
// Assumes: Same clock as the block
// Notes:   Wake source pulses dly_i cycles into sleep
`timescale 1ns/100ps
module smcg_partner (
    // Clock
    input  wire logic            ref_clk_i,
    // Bench control
    input  wire logic            go_i,
    input  wire logic [3:0]      dly_i,
    input  wire logic [4:0]      src_i,
    // Block side
    input  wire logic            sleeping_i,
    output smcg_pkg::smcg_wake_t wake_src_o = '0,
    output logic                 sleep_instr_o = 1'h0
);
    logic [3:0] cnt_r = 4'h0;
    // Sleep pulse and one-shot wake, prompt or slow
    always @(posedge ref_clk_i)
    begin
        sleep_instr_o <= go_i;
        cnt_r <= !sleeping_i ? 4'h0 : (cnt_r == 4'hf ? cnt_r : cnt_r + 4'h1);
        wake_src_o <= smcg_pkg::smcg_wake_t'((sleeping_i && cnt_r == dly_i) ? src_i : 5'h00);
    end
endmodule

// >>> test/tb_smcg_core.sv
// Purpose: Self-checking bench for sleep gating
// Assumes: Register port, partner drives sleep and wake
// Notes:   Sleep modes walked as a table of calls
`timescale 1ns/100ps
module tb_smcg_core;
    logic ref_clk = 1'h0, rst_n = 1'h0, go = 1'h0, conv = 1'h0, xtal = 1'h1;
    logic bod = 1'h0, dbg = 1'h0, tpe = 1'h0, shf = 1'h0, tdi = 1'h0, si, slp, wk, xc, tdo, oe;
    logic [2:0] ext = 3'h7;
    logic [3:0] dly = 4'h0;
    logic [4:0] src = 5'h10;
    logic [7:0] rdata;
    smcg_pkg::smcg_bus_req_t bus = '0;
    smcg_pkg::smcg_clk_t clk_en;
    smcg_pkg::smcg_sub_t sub_en;
    smcg_pkg::smcg_wake_t wsrc;
    int errors = 0, samples_checked = 0, cyc = 0;

    smcg_core i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .bus_i(bus), .rdata_o(rdata),
        .sleep_instr_i(si), .conversion_start_i(conv), .wake_src_i(wsrc),
        .ext_irq_line_i(ext), .crystal_select_i(xtal), .brownout_enable_fuse_i(bod),
        .debug_enable_fuse_i(dbg), .test_port_enable_fuse_i(tpe), .tap_shifting_i(shf),
        .tap_tdo_i(tdi), .clk_en_o(clk_en), .sub_en_o(sub_en), .tdo_o(tdo), .tdo_oe_o(oe),
        .sleeping_o(slp), .wake_o(wk), .extended_conv_o(xc));
    smcg_partner i_partner (.ref_clk_i(ref_clk), .go_i(go), .dly_i(dly), .src_i(src),
        .sleeping_i(slp), .wake_src_o(wsrc), .sleep_instr_o(si));

    // Clock and run limit
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= {a, d, 1'h1, 1'h0};
        @(posedge ref_clk);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        bus <= {a, 8'h00, 1'h0, 1'h1};
        @(posedge ref_clk);
        bus <= '0;
        #1 v = rdata;
    endtask
    task automatic go_p;
        @(posedge ref_clk);
        go <= 1'h1;
        @(posedge ref_clk);
        go <= 1'h0;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reg;
        logic [7:0] v;
        rd(8'h00, v);
        chk("ctrl", v, 8'h00);
        wr(8'h00, 8'hff);
        rd(8'h00, v);
        chk("ctrl ff", v, 8'h3f);
        rd(8'h05, v);
        chk("unmapped", v, 8'h00);
        wr(8'h00, 8'h00);
        $display("registers done");
    endtask
    task automatic t_pwr;
        wr(8'h01, 8'h01);
        tick(2);
        chk("xconv", xc, 1'h1);
        @(posedge ref_clk);
        conv <= 1'h1;
        @(posedge ref_clk);
        conv <= 1'h0;
        tick(2);
        chk("xconv clr", xc, 1'h0);
        wr(8'h01, 8'h04);
        tick(2);
        chk("vref cmp", sub_en[5:4], 2'h3);
        wr(8'h01, 8'h06);
        tick(2);
        chk("vref off", sub_en[5:3], 3'h0);
        @(posedge ref_clk);
        bod <= 1'h1;
        tick(5);
        chk("bod", sub_en[4:3], 2'h3);
        $display("power done");
    endtask
    task automatic t_jtag;
        @(posedge ref_clk);
        tpe <= 1'h1;
        shf <= 1'h1;
        tdi <= 1'h1;
        tick(6);
        chk("jtag on", {sub_en[0], oe, tdo}, 3'h7);
        wr(8'h00, 8'h20);
        tick(3);
        chk("jtag off", {sub_en[0], oe}, 2'h0);
        wr(8'h00, 8'h00);
        shf <= 1'h0;
        tick(6);
        chk("tdo float", {sub_en[0], oe}, 2'h2);
        @(posedge ref_clk);
        tpe <= 1'h0;
        tick(5);
        chk("fuse off", sub_en[0], 1'h0);
        $display("test port done");
    endtask
    task automatic t_ref(input logic [2:0] m, input logic x);
        logic [7:0] v;
        wr(8'h00, {5'h01, m});
        xtal <= x;
        tick(4);
        go_p();
        tick(4);
        chk("refused", slp, 1'h0);
        rd(8'h02, v);
        chk("refuse flag", v[7], 1'h1);
        $display("refusal %h done", m);
    endtask
    task automatic t_slp(input logic [2:0] m, input logic s, input logic d,
                         input logic [6:0] ec, input int n, input logic [3:0] w);
        int k;
        wr(8'h00, {3'h0, s, 1'h1, m});
        dbg <= d;
        xtal <= 1'h1;
        dly <= w;
        tick(4);
        go_p();
        for (k = 0; k < 8 && slp !== 1'h1; k++)
            tick(1);
        chk("clocks", clk_en, ec);
        chk("power", sub_en[6:1], {2'h2 | (m < 3'h2), 3'h7, ec[4] | ec[3]});
        for (k = 0; k < 8 && wsrc === '0; k++)
            tick(1);
        for (k = 0; k < 20 && wk !== 1'h1; k++)
            tick(1);
        chk("wake cycles", k, n + 1);
        $display("sleep mode %h done", m);
    endtask
    task automatic t_pins;
        wr(8'h01, 8'h08);
        wr(8'h00, 8'h0a);
        src <= 5'h00;
        go_p();
        repeat (3) @(posedge ref_clk);
        ext <= 3'h6;
        tick(10);
        chk("line0 edge", slp, 1'h1);
        @(posedge ref_clk);
        ext <= 3'h3;
        tick(24);
        chk("line2 wake", slp, 1'h0);
        @(posedge ref_clk);
        ext <= 3'h7;
        src <= 5'h10;
        $display("pin wake done");
    endtask

    // Main sequence
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'h1;
        #1 chk("clk reset", clk_en, 8'h7a);
        chk("sub reset", sub_en, 8'h00);
        tick(3);
        t_reg();
        t_pwr();
        t_jtag();
        t_ref(3'h4, 1'h1);
        t_ref(3'h6, 1'h0);
        wr(8'h01, 8'h09);
        t_slp(3'h0, 1'h1, 1'h0, 7'h1f, 1, 4'h0);
        t_slp(3'h0, 1'h0, 1'h0, 7'h1a, 1, 4'h5);
        t_slp(3'h1, 1'h1, 1'h0, 7'h0f, 1, 4'h0);
        t_slp(3'h2, 1'h1, 1'h0, 7'h00, 12, 4'h0);
        t_slp(3'h2, 1'h1, 1'h1, 7'h02, 12, 4'h0);
        t_slp(3'h3, 1'h1, 1'h0, 7'h05, 12, 4'h3);
        t_slp(3'h3, 1'h0, 1'h1, 7'h02, 12, 4'h0);
        t_slp(3'h6, 1'h1, 1'h0, 7'h02, 6, 4'h0);
        t_slp(3'h7, 1'h1, 1'h0, 7'h07, 6, 4'h0);
        t_slp(3'h7, 1'h0, 1'h0, 7'h02, 6, 4'h2);
        t_pins();
        conclude();
    end
endmodule

// >>> verilog/smcg_core.sv
// Purpose: Sleep mode clock gating and wake control
// Assumes: 20 MHz reference clock kept running, pins synchronised here
// Notes:   Registers on a plain 8-bit port, read data one cycle later
//
// How it works
// - Decode three-bit mode; codes four, five reserved
// - Idle stops only core and memory clocks
// - Power-down stops all clocks and main oscillator
// - Standby keeps oscillator; wakes in six cycles
// - Standby modes need crystal clock source
// - Async clock, timer osc, timer2 wake need select
// - Deep modes: only line2 edge, level lines0/1
// - Enabled converter stays enabled in sleep
// - Re-enabled converter: next conversion is extended
// - Comparator auto-off beyond idle and noise reduction
// - Comparator on reference keeps reference enabled
// - Reference on when any user needs it
// - Fused brown-out detector runs in all modes
// - Enabled watchdog keeps running in sleep
// - Input buffers off when io, converter clocks stop
// - Debug fuse keeps main clock in deep modes
// - Test port off by disable bit or fuse
// - TDO undriven unless test port shifting
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "smcg_map.svh"
module smcg_core (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_n_i,
    // Register port
    input  wire smcg_pkg::smcg_bus_req_t bus_i,
    output logic [7:0]                 rdata_o,
    // Core side, same clock
    input  wire logic                  sleep_instr_i,
    input  wire logic                  conversion_start_i,
    input  wire smcg_pkg::smcg_wake_t  wake_src_i,
    // Pins and fuses
    input  wire logic [2:0]            ext_irq_line_i,
    input  wire logic                  crystal_select_i,
    input  wire logic                  brownout_enable_fuse_i,
    input  wire logic                  debug_enable_fuse_i,
    input  wire logic                  test_port_enable_fuse_i,
    input  wire logic                  tap_shifting_i,
    input  wire logic                  tap_tdo_i,
    // Gating and power outputs
    output smcg_pkg::smcg_clk_t        clk_en_o,
    output smcg_pkg::smcg_sub_t        sub_en_o,
    output logic                       tdo_o,
    output logic                       tdo_oe_o,
    // Status
    output logic                       sleeping_o,
    output logic                       wake_o,
    output logic                       extended_conv_o
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        smcg_pkg::smcg_state_t state;
        logic [2:0]            mode;
        logic [7:0]            ctrl;
        logic [7:0]            pwr;
        logic                  refused;
        logic [3:0]            cnt;
        logic                  ext_conv;
        logic [2:0]            irq_prev;
        logic [7:0]            rdata;
        logic                  wake_p;
        smcg_pkg::smcg_clk_t   clk;
        smcg_pkg::smcg_sub_t   sub;
        logic                  tdo;
        logic                  tdo_oe;
    } smcg_st_t;

    smcg_st_t s_r;
    smcg_st_t s_nxt;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [8:0] pin_raw;
    logic [8:0] pin_q;

    // Gather pins into one vector
    assign pin_raw = {ext_irq_line_i, crystal_select_i, brownout_enable_fuse_i,
                      debug_enable_fuse_i, test_port_enable_fuse_i,
                      tap_shifting_i, tap_tdo_i};

    smcg_sync2 #(
        .W (9)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (pin_raw),
        .q_o       (pin_q)
    );

    // Split synchronised pins
    wire logic [2:0] irq_q       = pin_q[8:6];
    wire logic       xtal_q      = pin_q[5];
    wire logic       bod_fuse_q  = pin_q[4];
    wire logic       dbg_fuse_q  = pin_q[3];
    wire logic       tpe_fuse_q  = pin_q[2];
    wire logic       tap_shift_q = pin_q[1];
    wire logic       tap_tdo_q   = pin_q[0];

    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------

    // Mode code legal and allowed with the present clock source
    function automatic logic mode_ok(input logic [2:0] m, input logic xtal);
        logic ok;
        case (smcg_pkg::smcg_mode_t'(m))
            smcg_pkg::MODE_RSV4,
            smcg_pkg::MODE_RSV5:  ok = 1'b0;
            smcg_pkg::MODE_STBY,
            smcg_pkg::MODE_XSTBY: ok = xtal;
            default:              ok = 1'b1;
        endcase
        return ok;
    endfunction

    // Clock domains and oscillators left running in a sleep mode
    function automatic smcg_pkg::smcg_clk_t clocks_for(input logic [2:0] m,
                                                       input logic       asy,
                                                       input logic       dbg);
        smcg_pkg::smcg_clk_t c;
        c = '0;
        case (smcg_pkg::smcg_mode_t'(m))
            smcg_pkg::MODE_IDLE:
            begin
                c.io_clock          = 1'b1;
                c.converter_clock   = 1'b1;
                c.async_timer_clock = asy;
                c.main_osc          = 1'b1;
                c.timer_osc         = asy;
            end
            smcg_pkg::MODE_NR:
            begin
                c.converter_clock   = 1'b1;
                c.async_timer_clock = asy;
                c.main_osc          = 1'b1;
                c.timer_osc         = asy;
            end
            smcg_pkg::MODE_PD:
                c.main_osc = dbg;
            smcg_pkg::MODE_PS:
            begin
                c.async_timer_clock = asy;
                c.timer_osc         = asy;
                c.main_osc          = dbg;
            end
            smcg_pkg::MODE_STBY:
                c.main_osc = 1'b1;
            smcg_pkg::MODE_XSTBY:
            begin
                c.async_timer_clock = asy;
                c.timer_osc         = asy;
                c.main_osc          = 1'b1;
            end
            default:
                c.main_osc = 1'b1;
        endcase
        return c;
    endfunction

    // Cycles from wake event to running core
    function automatic logic [3:0] wake_cycles(input logic [2:0] m);
        logic [3:0] n;
        case (smcg_pkg::smcg_mode_t'(m))
            smcg_pkg::MODE_IDLE,
            smcg_pkg::MODE_NR:    n = `SMCG_IDLE_WAKE_CYC;
            smcg_pkg::MODE_STBY,
            smcg_pkg::MODE_XSTBY: n = `SMCG_STBY_WAKE_CYC;
            default:              n = `SMCG_PD_WAKE_CYC;
        endcase
        return n;
    endfunction

    // Wake source qualification
    logic            wake_hit;
    wire logic       asy_sel  = s_r.ctrl[`SMCG_CTRL_ASY_BIT];
    wire logic       lvl0     = s_r.pwr[`SMCG_PWR_LVL0_BIT] & ~irq_q[0];
    wire logic       lvl1     = s_r.pwr[`SMCG_PWR_LVL1_BIT] & ~irq_q[1];
    // Any edge on the three lines, or active level on lines zero and one
    wire logic       ext_any  = (|(irq_q ^ s_r.irq_prev)) | lvl0 | lvl1;
    // Line two edge, lines zero and one only as levels
    wire logic       ext_deep = (irq_q[2] ^ s_r.irq_prev[2]) | lvl0 | lvl1;
    wire logic       t2_ok    = wake_src_i.timer2_event & asy_sel;

    // Sources allowed per mode
    always_comb
    begin
        wake_hit = 1'b0;
        case (smcg_pkg::smcg_mode_t'(s_r.mode))
            smcg_pkg::MODE_IDLE:
                wake_hit = ext_any | wake_src_i.two_wire_port_match | t2_ok
                           | wake_src_i.spm_ready | wake_src_i.converter_done
                           | wake_src_i.other_io_irq;
            smcg_pkg::MODE_NR:
                wake_hit = ext_deep | wake_src_i.two_wire_port_match | t2_ok
                           | wake_src_i.spm_ready
                           | wake_src_i.converter_done;
            smcg_pkg::MODE_PS,
            smcg_pkg::MODE_XSTBY:
                wake_hit = ext_deep | wake_src_i.two_wire_port_match
                           | t2_ok;
            default:
                wake_hit = ext_deep
                           | wake_src_i.two_wire_port_match;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic                conv_on;
    logic                acd;
    logic                cmp_ref;
    logic                jtag_on;
    logic                deep;
    smcg_pkg::smcg_clk_t clk_sel;

    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.wake_p = 1'b0;
        s_nxt.irq_prev = irq_q;

        // Register writes, reserved bits kept zero
        if (bus_i.wr && bus_i.addr == `SMCG_CTRL_OFS)
            s_nxt.ctrl = bus_i.wdata & 8'h3f;
        if (bus_i.wr && bus_i.addr == `SMCG_PWR_OFS)
            s_nxt.pwr = bus_i.wdata & 8'h3f;
        // Extended conversion flag, set beats clear
        if (conversion_start_i)
            s_nxt.ext_conv = 1'b0;
        if (!s_r.pwr[`SMCG_PWR_CONV_BIT] && s_nxt.pwr[`SMCG_PWR_CONV_BIT])
            s_nxt.ext_conv = 1'b1;

        // Sleep sequencer
        case (s_r.state)
            smcg_pkg::ST_RUN:
            begin
                if (sleep_instr_i && s_r.ctrl[`SMCG_CTRL_SE_BIT])
                begin
                    if (mode_ok(s_r.ctrl[`SMCG_CTRL_MODE_MSB:`SMCG_CTRL_MODE_LSB],
                                xtal_q))
                    begin
                        s_nxt.state   = smcg_pkg::ST_SLEEP;
                        s_nxt.mode    = s_r.ctrl[`SMCG_CTRL_MODE_MSB:`SMCG_CTRL_MODE_LSB];
                        s_nxt.refused = 1'b0;
                    end
                    else
                        s_nxt.refused = 1'b1;
                end
            end
            smcg_pkg::ST_SLEEP:
            begin
                if (wake_hit)
                begin
                    s_nxt.state = smcg_pkg::ST_WAKE;
                    s_nxt.cnt   = wake_cycles(s_r.mode) - 4'h1;
                end
            end
            smcg_pkg::ST_WAKE:
            begin
                if (s_r.cnt == 4'h0)
                begin
                    s_nxt.state  = smcg_pkg::ST_RUN;
                    s_nxt.wake_p = 1'b1;
                end
                else
                    s_nxt.cnt = s_r.cnt - 4'h1;
            end
            default:
                s_nxt.state = smcg_pkg::ST_RUN;
        endcase

        // Clock gating for the coming cycle
        clk_sel = '1;
        clk_sel.async_timer_clock = s_nxt.ctrl[`SMCG_CTRL_ASY_BIT];
        clk_sel.timer_osc         = s_nxt.ctrl[`SMCG_CTRL_ASY_BIT];
        if (s_nxt.state != smcg_pkg::ST_RUN)
        begin
            clk_sel = clocks_for(s_nxt.mode, s_nxt.ctrl[`SMCG_CTRL_ASY_BIT],
                                 dbg_fuse_q);
        end
        if (s_nxt.state == smcg_pkg::ST_WAKE)
            clk_sel.main_osc = 1'b1;                             // Restart clock
        s_nxt.clk = clk_sel;

        // Subsystem power
        conv_on = s_nxt.pwr[`SMCG_PWR_CONV_BIT];
        acd     = s_nxt.pwr[`SMCG_PWR_ACD_BIT];
        cmp_ref = s_nxt.pwr[`SMCG_PWR_AREF_BIT] & ~acd;
        deep    = (s_nxt.state != smcg_pkg::ST_RUN)
                  && s_nxt.mode != 3'(smcg_pkg::MODE_IDLE)
                  && s_nxt.mode != 3'(smcg_pkg::MODE_NR);
        jtag_on = tpe_fuse_q & ~s_nxt.ctrl[`SMCG_CTRL_TPD_BIT];
        s_nxt.sub.converter    = conv_on;
        s_nxt.sub.comparator   = ~acd & ~deep;
        s_nxt.sub.vref         = bod_fuse_q | cmp_ref | conv_on;
        s_nxt.sub.brownout     = bod_fuse_q;
        s_nxt.sub.watchdog     = s_nxt.pwr[`SMCG_PWR_WDT_BIT];
        s_nxt.sub.input_buffer = clk_sel.io_clock
                                 | clk_sel.converter_clock;
        s_nxt.sub.jtag         = jtag_on;

        // Test data out, driven only while shifting
        s_nxt.tdo    = tap_tdo_q;
        s_nxt.tdo_oe = jtag_on & tap_shift_q;

        // Read data, one cycle after the strobe
        s_nxt.rdata = 8'h00;
        if (bus_i.rd)
        begin
            case (bus_i.addr)
                `SMCG_CTRL_OFS: s_nxt.rdata = s_r.ctrl;
                `SMCG_PWR_OFS:  s_nxt.rdata = s_r.pwr;
                `SMCG_STAT_OFS:
                begin
                    s_nxt.rdata[`SMCG_STAT_MODE_MSB:`SMCG_STAT_MODE_LSB] = s_r.mode;
                    s_nxt.rdata[`SMCG_STAT_SLP_BIT]   = (s_r.state == smcg_pkg::ST_SLEEP);
                    s_nxt.rdata[`SMCG_STAT_WAKE_BIT]  = (s_r.state == smcg_pkg::ST_WAKE);
                    s_nxt.rdata[`SMCG_STAT_XCONV_BIT] = s_r.ext_conv;
                    s_nxt.rdata[`SMCG_STAT_JTAG_BIT]  = s_r.sub.jtag;
                    s_nxt.rdata[`SMCG_STAT_REF_BIT]   = s_r.refused;
                end
                default:        s_nxt.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            s_r       <= '0;
            s_r.state <= smcg_pkg::ST_RUN;
            s_r.ctrl  <= `SMCG_CTRL_RST;
            s_r.pwr   <= `SMCG_PWR_RST;
            s_r.clk   <= 7'h7a;                                  // Run clocks on
            s_r.irq_prev <= 3'h7;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs from the state record
    assign rdata_o         = s_r.rdata;
    assign clk_en_o        = s_r.clk;
    assign sub_en_o        = s_r.sub;
    assign tdo_o           = s_r.tdo;
    assign tdo_oe_o        = s_r.tdo_oe;
    assign sleeping_o      = (s_r.state != smcg_pkg::ST_RUN);
    assign wake_o          = s_r.wake_p;
    assign extended_conv_o = s_r.ext_conv;

endmodule

// >>> verilog/smcg_map.svh
// Purpose: Register map, field positions, reset values and wake counts
// Assumes: 8-bit register port, one clock
// Notes:   Definitions only
`ifndef SMCG_MAP_SVH
`define SMCG_MAP_SVH

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define SMCG_CTRL_OFS       8'h00
`define SMCG_PWR_OFS        8'h01
`define SMCG_STAT_OFS       8'h02

// Control register fields
`define SMCG_CTRL_MODE_LSB  0
`define SMCG_CTRL_MODE_MSB  2
`define SMCG_CTRL_SE_BIT    3
`define SMCG_CTRL_ASY_BIT   4
`define SMCG_CTRL_TPD_BIT   5
`define SMCG_CTRL_RST       8'h00

// Power register fields
`define SMCG_PWR_CONV_BIT   0
`define SMCG_PWR_ACD_BIT    1
`define SMCG_PWR_AREF_BIT   2
`define SMCG_PWR_WDT_BIT    3
`define SMCG_PWR_LVL0_BIT   4
`define SMCG_PWR_LVL1_BIT   5
`define SMCG_PWR_RST        8'h00

// Status register fields
`define SMCG_STAT_MODE_LSB  0
`define SMCG_STAT_MODE_MSB  2
`define SMCG_STAT_SLP_BIT   3
`define SMCG_STAT_WAKE_BIT  4
`define SMCG_STAT_XCONV_BIT 5
`define SMCG_STAT_JTAG_BIT  6
`define SMCG_STAT_REF_BIT   7

// ----------------------------------------------------------------
// Wake-up counts in clock cycles
// ----------------------------------------------------------------
`define SMCG_IDLE_WAKE_CYC  4'h1
`define SMCG_STBY_WAKE_CYC  4'h6
`define SMCG_PD_WAKE_CYC    4'hc

`endif

// >>> verilog/smcg_pkg.sv
// Purpose: Types shared by the sleep clock gating block
// Assumes: Constants live in smcg_map.svh
// Notes:   Enums use one-hot or documented codes
package smcg_pkg;

    // ------------------------------------------------------------
    // Sleep mode and controller state codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_IDLE  = 3'h0,
        MODE_NR    = 3'h1,
        MODE_PD    = 3'h2,
        MODE_PS    = 3'h3,
        MODE_RSV4  = 3'h4,
        MODE_RSV5  = 3'h5,
        MODE_STBY  = 3'h6,
        MODE_XSTBY = 3'h7
    } smcg_mode_t;

    // Controller states
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE  = 3'b100
    } smcg_state_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } smcg_bus_req_t;

    typedef struct packed {
        logic core_clock;
        logic program_memory_clock;
        logic io_clock;
        logic converter_clock;
        logic async_timer_clock;
        logic main_osc;
        logic timer_osc;
    } smcg_clk_t;

    typedef struct packed {
        logic converter;
        logic comparator;
        logic vref;
        logic brownout;
        logic watchdog;
        logic input_buffer;
        logic jtag;
    } smcg_sub_t;

    typedef struct packed {
        logic two_wire_port_match;
        logic timer2_event;
        logic spm_ready;
        logic converter_done;
        logic other_io_irq;
    } smcg_wake_t;

endpackage

// >>> verilog/smcg_sync2.sv
// Purpose: Two-stage synchroniser for pin-level inputs
// Assumes: Inputs may change at any time
// Notes:   First stage feeds only the second
`timescale 1ns/100ps
module smcg_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } smcg_sync_st_t;

    smcg_sync_st_t s_r;
    smcg_sync_st_t s_nxt;

    // Shift through both stages
    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.meta = d_i;
        s_nxt.q    = s_r.meta;
    end

    // State register
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign q_o = s_r.q;

endmodule
